// ---- pkg/pcfgs_pkg.sv ----
// package for the configuration header status slice: offsets, fields, reset values, carriers
package pcfgs_pkg;

  // doubleword byte addresses of the configuration header
  localparam logic [7:0] CMD_STATUS_DW = 8'h04;
  localparam logic [7:0] REV_CLASS_DW = 8'h08;
  localparam logic [7:0] LINE_LAT_DW = 8'h0C;

  // byte offsets as printed, for reference in lane decode
  localparam logic [7:0] SILICON_REVISION_OFS = 8'h08;
  localparam logic [7:0] DEVICE_CLASS_CODE_OFS = 8'h09;
  localparam logic [7:0] CACHE_LINE_LENGTH_OFS = 8'h0C;
  localparam logic [7:0] INITIATOR_LATENCY_LIMIT_OFS = 8'h0D;

  // status bit positions
  localparam int PARITY_SEEN_BIT = 15;
  localparam int SYSTEM_FAULT_SENT_BIT = 14;
  localparam int INITIATOR_ABORT_BIT = 13;
  localparam int TARGET_ABORT_GOT_BIT = 12;
  localparam int TARGET_ABORT_SENT_BIT = 11;
  localparam int SELECT_TIMING_LSB = 9;
  localparam int MASTER_DATA_PARITY_BIT = 8;
  localparam int BACK_TO_BACK_BIT = 7;
  localparam int USER_FEATURE_BIT = 6;
  localparam int DOUBLE_RATE_BIT = 5;
  localparam int CAPABILITY_CHAIN_BIT = 4;

  // command bit positions referenced by the status logic
  localparam int SYSTEM_FAULT_ENABLE_BIT = 8;
  localparam int PARITY_RESPONSE_BIT = 6;

  // hardwired field values
  localparam logic [1:0] SELECT_TIMING_MEDIUM = 2'h1;
  localparam logic back_to_back_capable = 1'b0;
  localparam logic user_feature_support = 1'b0;
  localparam logic double_rate_capable = 1'b0;
  localparam logic capability_chain_present = 1'b1;
  localparam logic [23:0] CLASS_CODE_VALUE = 24'h060700;

  // reset values
  localparam logic [7:0] CACHE_LINE_RESET = 8'h00;
  localparam logic [7:0] LATENCY_LIMIT_RESET = 8'h00;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic FLAG_RESET = 1'b0;

  // number of functions sharing the bus interface
  localparam int NUM_FUNCS = 2;

  // configuration access from the target interface
  typedef struct packed {
    logic valid;
    logic write;
    logic func;
    logic [7:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } pcfgs_cfg_req_t;

  // bus events observed by the interface logic, for one function
  typedef struct packed {
    logic parity_error;
    logic serr_signalled;
    logic master_abort;
    logic target_abort_rcvd;
    logic target_abort_sent;
    logic perr_while_master;
  } pcfgs_events_t;

  // initiator view of the bus for one function
  typedef struct packed {
    logic frame_start;
    logic active;
    logic gnt;
  } pcfgs_init_t;

endpackage : pcfgs_pkg

// ---- core/pcfgs_latency.sv ----
// per-function initiator latency counter with expiry and early termination request
`timescale 1ns/10ps
`default_nettype none

module pcfgs_latency #(
  parameter int CNT_W = 8
) (
  input wire logic sys_clk_in, // bus clock
  input wire logic rst_n_in, // synchronous reset, active low
  input wire logic [CNT_W-1:0] limit_in, // programmed latency limit
  input wire pcfgs_pkg::pcfgs_init_t init_in, // initiator status
  output logic expired_out, // limit reached during this tenure
  output logic end_now_out // end the transaction now
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic expired;
  } pcfgs_lat_state_t;

  pcfgs_lat_state_t state;
  pcfgs_lat_state_t next_state;

  // counter restarts at zero on each frame start and advances every clock while active until the limit is reached, then holds
  always_comb begin
    next_state = state;
    if (init_in.frame_start) begin
      next_state.count = '0;
      next_state.expired = (limit_in == '0);
    end else if (init_in.active) begin
      if (!state.expired) begin
        next_state.count = state.count + CNT_W'(1);
        if (state.count + CNT_W'(1) >= limit_in) begin
          next_state.expired = 1'b1;
        end
      end
    end else begin
      next_state.expired = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign expired_out = state.expired;
  // give up the bus only once the grant has gone; a kept grant lets the burst continue
  assign end_now_out = state.expired && init_in.active && !init_in.gnt;

endmodule : pcfgs_latency

`default_nettype wire

// ---- core/pcfgs_status_bank.sv ----
// configuration header status, revision, class, cache line and latency registers
`timescale 1ns/10ps
`default_nettype none

module pcfgs_status_bank #(
  parameter logic [7:0] SILICON_REVISION = 8'h5A, // value arbitrary
  parameter int CNT_W = 8
) (
  input wire logic sys_clk_in, // bus clock, 10 MHz
  input wire logic rst_n_in, // synchronous reset, active low
  input wire pcfgs_pkg::pcfgs_cfg_req_t cfg_req_in, // configuration access
  output logic [31:0] cfg_rdata_out, // read data, registered
  output logic cfg_ack_out, // access done, one-cycle pulse
  input wire logic [1:0] system_fault_enable_in, // command bit 8 per function
  input wire logic [1:0] parity_response_enable_in, // command bit 6 per function
  input wire pcfgs_pkg::pcfgs_events_t [1:0] events_in, // bus events per function
  input wire logic addr_parity_error_in, // address phase parity error seen
  output logic serr_req_out, // request to drive system error
  input wire pcfgs_pkg::pcfgs_init_t [1:0] init_in, // initiator status per function
  output logic [1:0] latency_expired_out, // latency limit reached per function
  output logic [1:0] initiator_end_out // end own transaction per function
);

  typedef struct packed {
    logic parity_seen_flag;
    logic system_fault_sent_flag;
    logic initiator_abort_flag;
    logic target_abort_got_flag;
    logic target_abort_sent_flag;
    logic master_data_parity_flag;
  } pcfgs_flags_t;

  typedef struct packed {
    pcfgs_flags_t [1:0] flags;
    logic [1:0][7:0] cache_line_length;
    logic [1:0][7:0] initiator_latency_limit;
    logic [31:0] rdata;
    logic ack;
  } pcfgs_state_t;

  pcfgs_state_t state;
  pcfgs_state_t next_state;
  logic [1:0] serr_fire;
  logic [1:0] system_fault_output_enable;
  logic [1:0] parity_response_enable;

  // merge a byte into a lane only when its enable is set
  function automatic logic [7:0] lane_merge(input logic [7:0] old_v, input logic [7:0] new_v, input logic en);
    lane_merge = en ? new_v : old_v;
  endfunction : lane_merge

  // sticky flag: a fresh event wins over a write-one clear in the same cycle
  function automatic logic sticky(input logic cur, input logic set_ev, input logic clr);
    sticky = set_ev | (cur & ~clr);
  endfunction : sticky

  // pack the 16-bit status word of one function
  function automatic logic [15:0] status_word(input pcfgs_flags_t f);
    logic [15:0] w;
    w = 16'h0000;
    w[pcfgs_pkg::PARITY_SEEN_BIT] = f.parity_seen_flag;
    w[pcfgs_pkg::SYSTEM_FAULT_SENT_BIT] = f.system_fault_sent_flag;
    w[pcfgs_pkg::INITIATOR_ABORT_BIT] = f.initiator_abort_flag;
    w[pcfgs_pkg::TARGET_ABORT_GOT_BIT] = f.target_abort_got_flag;
    w[pcfgs_pkg::TARGET_ABORT_SENT_BIT] = f.target_abort_sent_flag;
    w[pcfgs_pkg::SELECT_TIMING_LSB +: 2] = pcfgs_pkg::SELECT_TIMING_MEDIUM;
    w[pcfgs_pkg::MASTER_DATA_PARITY_BIT] = f.master_data_parity_flag;
    w[pcfgs_pkg::BACK_TO_BACK_BIT] = pcfgs_pkg::back_to_back_capable;
    w[pcfgs_pkg::USER_FEATURE_BIT] = pcfgs_pkg::user_feature_support;
    w[pcfgs_pkg::DOUBLE_RATE_BIT] = pcfgs_pkg::double_rate_capable;
    w[pcfgs_pkg::CAPABILITY_CHAIN_BIT] = pcfgs_pkg::capability_chain_present;
    status_word = w;
  endfunction : status_word

  assign system_fault_output_enable = system_fault_enable_in;
  assign parity_response_enable = parity_response_enable_in;

  // address parity reaches the system error line only with both enables set per function
  always_comb begin
    for (int i = 0; i < pcfgs_pkg::NUM_FUNCS; i++) begin
      serr_fire[i] = addr_parity_error_in && system_fault_output_enable[i] && parity_response_enable[i];
    end
  end
  assign serr_req_out = |serr_fire;

  // one next-state process for flags, writable bytes and the read path
  always_comb begin
    logic wr;
    logic rd;
    logic fsel;
    logic [15:0] clr;
    next_state = state;
    wr = cfg_req_in.valid && cfg_req_in.write;
    rd = cfg_req_in.valid && !cfg_req_in.write;
    fsel = cfg_req_in.func;
    clr = 16'h0000;
    next_state.ack = cfg_req_in.valid;
    next_state.rdata = state.rdata;

    // status clear only through the upper half lanes of the command/status doubleword
    for (int i = 0; i < pcfgs_pkg::NUM_FUNCS; i++) begin
      clr = 16'h0000;
      if (wr && fsel == 1'(i) && cfg_req_in.addr == pcfgs_pkg::CMD_STATUS_DW) begin
        clr[7:0] = cfg_req_in.byte_en[2] ? cfg_req_in.wdata[23:16] : 8'h00;
        clr[15:8] = cfg_req_in.byte_en[3] ? cfg_req_in.wdata[31:24] : 8'h00;
      end
      next_state.flags[i].parity_seen_flag = sticky(state.flags[i].parity_seen_flag,
        events_in[i].parity_error, clr[pcfgs_pkg::PARITY_SEEN_BIT]);
      next_state.flags[i].system_fault_sent_flag = sticky(state.flags[i].system_fault_sent_flag,
        system_fault_output_enable[i] && (events_in[i].serr_signalled || serr_fire[i]),
        clr[pcfgs_pkg::SYSTEM_FAULT_SENT_BIT]);
      next_state.flags[i].initiator_abort_flag = sticky(state.flags[i].initiator_abort_flag,
        events_in[i].master_abort, clr[pcfgs_pkg::INITIATOR_ABORT_BIT]);
      next_state.flags[i].target_abort_got_flag = sticky(state.flags[i].target_abort_got_flag,
        events_in[i].target_abort_rcvd, clr[pcfgs_pkg::TARGET_ABORT_GOT_BIT]);
      next_state.flags[i].target_abort_sent_flag = sticky(state.flags[i].target_abort_sent_flag,
        events_in[i].target_abort_sent, clr[pcfgs_pkg::TARGET_ABORT_SENT_BIT]);
      next_state.flags[i].master_data_parity_flag = sticky(state.flags[i].master_data_parity_flag,
        events_in[i].perr_while_master && parity_response_enable[i],
        clr[pcfgs_pkg::MASTER_DATA_PARITY_BIT]);
    end

    // cache line and latency bytes: only lanes 0 and 1 of doubleword 0Ch are writable
    if (wr && cfg_req_in.addr == pcfgs_pkg::LINE_LAT_DW) begin
      next_state.cache_line_length[fsel] = lane_merge(state.cache_line_length[fsel],
        cfg_req_in.wdata[7:0], cfg_req_in.byte_en[0]);
      next_state.initiator_latency_limit[fsel] = lane_merge(state.initiator_latency_limit[fsel],
        cfg_req_in.wdata[15:8], cfg_req_in.byte_en[1]);
    end

    // read path; unmapped doublewords read zero, command half is not held here
    if (rd) begin
      case (cfg_req_in.addr)
        pcfgs_pkg::CMD_STATUS_DW: next_state.rdata = {status_word(state.flags[fsel]), 16'h0000};
        pcfgs_pkg::REV_CLASS_DW: next_state.rdata = {pcfgs_pkg::CLASS_CODE_VALUE, SILICON_REVISION};
        pcfgs_pkg::LINE_LAT_DW: next_state.rdata = {16'h0000, state.initiator_latency_limit[fsel],
          state.cache_line_length[fsel]};
        default: next_state.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state <= '0;
      state.cache_line_length <= {pcfgs_pkg::CACHE_LINE_RESET, pcfgs_pkg::CACHE_LINE_RESET};
      state.initiator_latency_limit <= {pcfgs_pkg::LATENCY_LIMIT_RESET, pcfgs_pkg::LATENCY_LIMIT_RESET};
    end else begin
      state <= next_state;
    end
  end

  assign cfg_rdata_out = state.rdata;
  assign cfg_ack_out = state.ack;

  // independent counters so the platform can weigh each function's bus share
  for (genvar g = 0; g < 2; g++) begin : g_lat
    pcfgs_latency #(
      .CNT_W(CNT_W)
    ) u_lat (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .limit_in(CNT_W'(state.initiator_latency_limit[g])),
      .init_in(init_in[g]),
      .expired_out(latency_expired_out[g]),
      .end_now_out(initiator_end_out[g])
    );
  end

endmodule : pcfgs_status_bank

`default_nettype wire

// ---- tb/pcfgs_status_asserts.sv ----
// checker on the status bank ports
`timescale 1ns/10ps
`default_nettype none
module pcfgs_status_asserts #(
  parameter logic [7:0] SILICON_REVISION = 8'h5A, // value arbitrary
  parameter int CNT_W = 8
) (
  input wire logic sys_clk_in, // clock
  input wire logic rst_n_in, // reset
  input wire pcfgs_pkg::pcfgs_cfg_req_t cfg_req_in, // access
  input wire logic [31:0] cfg_rdata_out, // read data
  input wire logic cfg_ack_out, // done
  input wire logic [1:0] system_fault_enable_in, // enables
  input wire logic [1:0] parity_response_enable_in, // enables
  input wire pcfgs_pkg::pcfgs_events_t [1:0] events_in, // events
  input wire logic addr_parity_error_in, // address parity
  input wire logic serr_req_out, // system error
  input wire pcfgs_pkg::pcfgs_init_t [1:0] init_in, // tenure
  input wire logic [1:0] latency_expired_out, // expiry
  input wire logic [1:0] initiator_end_out // end request
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // a read of one doubleword of one function, data follows a cycle later
  sequence rd_s(logic [7:0] a, logic f);
    cfg_req_in.valid && !cfg_req_in.write && cfg_req_in.addr == a && cfg_req_in.func == f;
  endsequence
  ack_next_a: assert property (cfg_req_in.valid |=> cfg_ack_out) else $error("ack missing");
  ack_only_a: assert property (!cfg_req_in.valid |=> !cfg_ack_out) else $error("stray ack");
  fixed_bits_a: assert property (rd_s(8'h04, 1'b0) |=> cfg_rdata_out[26:25] == 2'h1
    && cfg_rdata_out[23:16] == 8'h10) else $error("status fixed bits wrong");
  class_rev_a: assert property (rd_s(8'h08, 1'b1) |=> cfg_rdata_out == {24'h060700, SILICON_REVISION})
    else $error("class or revision wrong");
  abort_flag_a: assert property (events_in[0].master_abort ##1 rd_s(8'h04, 1'b0) |=> cfg_rdata_out[29])
    else $error("abort flag not set");
  serr_map_a: assert property (serr_req_out == (addr_parity_error_in
    && |(system_fault_enable_in & parity_response_enable_in))) else $error("serr request wrong");
  end_map_a: assert property (initiator_end_out == (latency_expired_out
    & {init_in[1].active, init_in[0].active} & ~{init_in[1].gnt, init_in[0].gnt})) else $error("end wrong");
  idle_clear_a: assert property (!init_in[0].active && !init_in[0].frame_start |=> !latency_expired_out[0])
    else $error("expiry outside tenure");
endmodule : pcfgs_status_asserts
bind pcfgs_status_bank pcfgs_status_asserts #(.SILICON_REVISION(SILICON_REVISION), .CNT_W(CNT_W)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cfg_req_in(cfg_req_in), .cfg_rdata_out(cfg_rdata_out),
  .cfg_ack_out(cfg_ack_out), .system_fault_enable_in(system_fault_enable_in),
  .parity_response_enable_in(parity_response_enable_in), .events_in(events_in),
  .addr_parity_error_in(addr_parity_error_in), .serr_req_out(serr_req_out), .init_in(init_in),
  .latency_expired_out(latency_expired_out), .initiator_end_out(initiator_end_out));
`default_nettype wire

// ---- tb/pcfgs_bus_model.sv ----
// bus agent model: one initiator tenure at a time, grant removed after a set delay
`timescale 1ns/10ps
`default_nettype none
module pcfgs_bus_model (
  input wire logic sys_clk_in, // clock
  input wire logic rst_n_in, // reset, active low
  input wire logic go_in, // start a tenure
  input wire logic func_in, // owning function
  input wire logic [7:0] gnt_len_in, // cycles until grant removal
  input wire logic [1:0] end_in, // end request from the bank
  output var pcfgs_pkg::pcfgs_init_t [1:0] init_out, // tenure status
  output logic busy_out // tenure running
);
  logic [7:0] cnt;
  logic f;
  // the tenure only ends on request, so a bank that never ends it uses up the 300-cycle wait
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      init_out <= '0;
      busy_out <= 1'b0;
      cnt <= 8'h00;
      f <= 1'b0;
    end else if (go_in && !busy_out) begin
      busy_out <= 1'b1;
      f <= func_in;
      cnt <= 8'h00;
      init_out[func_in] <= 3'h7;
    end else if (busy_out) begin
      init_out[f].frame_start <= 1'b0;
      cnt <= cnt + 8'h01;
      if (cnt + 8'h01 >= gnt_len_in) init_out[f].gnt <= 1'b0;
      if (end_in[f]) begin
        busy_out <= 1'b0;
        init_out[f] <= '0;
      end
    end
  end
endmodule : pcfgs_bus_model
`default_nettype wire

// ---- tb/pci_config_header_status_tb_top.sv ----
// self-checking bench for the configuration status bank
`timescale 1ns/10ps
`default_nettype none
module pci_config_header_status_tb_top;
  localparam logic [7:0] REV = 8'h3C; // value arbitrary
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  pcfgs_pkg::pcfgs_cfg_req_t req = '0;
  pcfgs_pkg::pcfgs_events_t [1:0] ev = '0;
  pcfgs_pkg::pcfgs_init_t [1:0] init;
  logic [31:0] rdata, q, d;
  logic ack, serr, busy, f, en, ap = 1'b0, go = 1'b0, gf = 1'b0;
  logic [1:0] sfe = '0, pre = '0, lexp, iend;
  logic [7:0] glen = '0, lim;
  logic [7:0] cl [2] = '{8'h00, 8'h00};
  logic [7:0] lt [2] = '{8'h00, 8'h00};
  logic [3:0] be;
  int num_errors = 0, check_count = 0, n;
  always #50 sys_clk_in = ~sys_clk_in;
  pcfgs_status_bank #(.SILICON_REVISION(REV)) u_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .cfg_req_in(req), .cfg_rdata_out(rdata), .cfg_ack_out(ack), .system_fault_enable_in(sfe),
    .parity_response_enable_in(pre), .events_in(ev), .addr_parity_error_in(ap), .serr_req_out(serr),
    .init_in(init), .latency_expired_out(lexp), .initiator_end_out(iend));
  pcfgs_bus_model u_bus (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .go_in(go), .func_in(gf),
    .gnt_len_in(glen), .end_in(iend), .init_out(init), .busy_out(busy));
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // a used-up wait is a failure and ends the run
  task automatic bound(input int lim_n);
    if (n >= lim_n) begin
      chk("wait", 32'h0, 32'h1);
      stop_test();
    end
  endtask : bound
  // one access; pending event pulses end at the request edge
  task automatic cfg(input logic w, input logic fn, input logic [7:0] a, input logic [3:0] b, input logic [31:0] wd);
    @(posedge sys_clk_in);
    req <= '{1'b1, w, fn, a, b, wd};
    ev <= '0;
    ap <= 1'b0;
    @(posedge sys_clk_in);
    req.valid <= 1'b0;
    @(negedge sys_clk_in);
    chk("ack", 32'h1, {31'h0, ack});
    q = rdata;
  endtask : cfg
  function automatic logic [31:0] flag_exp(input int j, input logic e);
    logic [15:0] pos [6] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0100};
    if (!e && (j == 1 || j == 5)) return 32'h0210_0000;
    return {pos[j] | 16'h0210, 16'h0000};
  endfunction : flag_exp
  initial begin
    void'($urandom(32'h759d));
    repeat (16) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      cfg(1'b0, i[0], 8'h0C, 4'h0, 32'h0);
      chk("line_lat", 32'h0, q);
      cfg(1'b0, i[0], 8'h04, 4'h0, 32'h0);
      chk("status", 32'h0210_0000, q);
      cfg(1'b1, i[0], 8'h08, 4'hF, $urandom);
      cfg(1'b0, i[0], 8'h08, 4'h0, 32'h0);
      chk("rev_class", {24'h060700, REV}, q);
      cfg(1'b0, i[0], 8'h10, 4'h0, 32'h0);
      chk("unmapped", 32'h0, q);
    end
    // random lane writes, each function kept apart
    repeat (10) begin
      f = 1'($urandom_range(1));
      be = 4'($urandom);
      d = $urandom;
      cfg(1'b1, f, 8'h0C, be, d);
      if (be[0]) cl[f] = d[7:0];
      if (be[1]) lt[f] = d[15:8];
      cfg(1'b0, f, 8'h0C, 4'h0, 32'h0);
      chk("line_lat", {16'h0, lt[f], cl[f]}, q);
    end
    // every event twice, enables set at random on each pass, then zero write and one write
    for (int k = 0; k < 12; k++) begin
      f = 1'($urandom_range(1));
      en = 1'($urandom_range(1));
      @(posedge sys_clk_in);
      sfe <= {2{en}};
      pre <= {2{en}};
      @(posedge sys_clk_in);
      ev[f] <= 6'h20 >> (k % 6);
      cfg(1'b0, f, 8'h04, 4'h0, 32'h0);
      chk("status", flag_exp(k % 6, en), q);
      cfg(1'b1, f, 8'h04, 4'hC, 32'h0);
      cfg(1'b0, f, 8'h04, 4'h0, 32'h0);
      chk("status", flag_exp(k % 6, en), q);
      cfg(1'b1, f, 8'h04, 4'hC, 32'hFFFF_0000);
      cfg(1'b0, f, 8'h04, 4'h0, 32'h0);
      chk("status", 32'h0210_0000, q);
    end
    // address parity with one function fully enabled, then with none
    @(posedge sys_clk_in);
    sfe <= 2'h1;
    pre <= 2'h3;
    ap <= 1'b1;
    @(negedge sys_clk_in);
    chk("serr", 32'h1, {31'h0, serr});
    cfg(1'b0, 1'b0, 8'h04, 4'h0, 32'h0);
    chk("apar_f0", 32'h1, {31'h0, q[30]});
    cfg(1'b0, 1'b1, 8'h04, 4'h0, 32'h0);
    chk("apar_f1", 32'h0, {31'h0, q[30]});
    @(posedge sys_clk_in);
    sfe <= 2'h2;
    pre <= 2'h1;
    ap <= 1'b1;
    @(negedge sys_clk_in);
    chk("serr", 32'h0, {31'h0, serr});
    // latency tenures on random functions and limits
    repeat (4) begin
      f = 1'($urandom_range(1));
      lim = 8'($urandom_range(20));
      cfg(1'b1, f, 8'h0C, 4'h2, {16'h0, lim, 8'h00});
      @(posedge sys_clk_in);
      go <= 1'b1;
      gf <= f;
      glen <= lim + 8'h03;
      @(posedge sys_clk_in);
      go <= 1'b0;
      n = 0;
      do begin @(negedge sys_clk_in); n++; end while (init[f].frame_start !== 1'b1 && n < 50);
      bound(50);
      n = 0;
      do begin @(negedge sys_clk_in); n++; end while (lexp[f] !== 1'b1 && n < 300);
      bound(300);
      chk("lat_cycles", 32'(lim) + 32'h1, 32'(n));
      chk("lat_other", 32'h0, {31'h0, lexp[~f]});
      n = 0;
      while (busy !== 1'b0 && n < 300) begin @(negedge sys_clk_in); n++; end
      bound(300);
      chk("tenure_end", 32'h0, {31'h0, busy});
    end
    stop_test();
  end
endmodule : pci_config_header_status_tb_top
`default_nettype wire
